// [include/ivp_defines.vh]
`ifndef IVP_DEFINES_VH
`define IVP_DEFINES_VH

// Register byte offsets
`define OFS_SRC_EN 8'h00
`define OFS_FLAGS 8'h04
`define OFS_IRQ_MASK 8'h08
`define OFS_SLEEP 8'h0C
`define OFS_STATUS 8'h10
`define OFS_VEC_BASE 8'h40

// Source enable bits
`define EN_NMI_PIN 0
`define EN_OSC_FAULT 1
`define EN_ACC_VIOL 2
`define EN_CONVERTER 4
`define EN_TIMER 5
`define EN_PORT_ONE 6
`define EN_PORT_TWO 7
`define SRC_EN_RST 8'h00

// Flag bits
`define FL_NMI_PIN 0
`define FL_OSC_FAULT 1
`define FL_ACC_VIOL 2
`define FL_WATCHDOG 3
`define FL_KEY_VIOL 4
`define FL_BAD_FETCH 5
`define FLAGS_W 6
`define FLAGS_RST 6'h02
`define MASK_RST 6'h00

// Vector region and priorities
`define VEC_TOP 16'hFFFF
`define VEC_LOW 16'hFFE0
`define PRI_RESET 15
`define PRI_NMI 14
`define PRI_CONVERTER 12
`define PRI_TIMER 5
`define PRI_PORT_ONE 4
`define PRI_PORT_TWO 1

// Fetch trap ranges
`define PERIPH_LAST 16'h01FF
`define HOLE_FIRST 16'h0600
`define HOLE_LAST 16'h0BFF

// Sleep mode codes
`define MODE_ACTIVE 3'h0
`define MODE_SLEEP0 3'h1
`define MODE_SLEEP1 3'h2
`define MODE_SLEEP2 3'h3
`define MODE_SLEEP3 3'h4
`define MODE_SLEEP4 3'h5
`define MODE_RST 3'h0

// Clock enable patterns: {xtal, dc_gen, osc_out, fll, aclk, sub_main_clock, mclk, cpu}
`define CLK_ACTIVE 8'hFF
`define CLK_SLEEP0 8'hFE
`define CLK_SLEEP1 8'hEE
`define CLK_SLEEP2 8'hC8
`define CLK_SLEEP3 8'h88
`define CLK_SLEEP4 8'h00

// Clock enable bit positions inside a pattern
`define CK_CPU 0
`define CK_MCLK 1
`define CK_SUB_MAIN_CLOCK 2
`define CK_ACLK 3
`define CK_FLL 4
`define CK_OSC_OUT 5
`define CK_DC_GEN 6
`define CK_XTAL 7

// Status word field positions
`define ST_BEST_LSB 16
`define ST_ANY_BIT 20
`define ST_MODE_LSB 21
`define ST_NEST_LSB 24

`endif

// [rtl/int_vector_ctrl.v]
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ivp_defines.vh"
module int_vector_ctrl (
	input wire mclk_i,
	input wire reset_n_i,
	// AHB-Lite slave
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	output reg hreadyout_o,
	output reg hresp_o,
	output reg [31:0] hrdata_o,
	// Event sources
	input wire ext_reset_i,
	input wire watchdog_expire_i,
	input wire key_violation_i,
	input wire nmi_pin_i,
	input wire osc_fault_i,
	input wire flash_access_viol_i,
	input wire converter_req_i,
	input wire timer_req_i,
	input wire [7:0] port_one_change_flags_i,
	input wire [7:0] port_two_change_flags_i,
	// Core side
	input wire gie_i,
	input wire fetch_valid_i,
	input wire [15:0] fetch_addr_i,
	input wire int_ack_i,
	input wire reti_i,
	output reg int_req_o,
	output reg reset_req_o,
	output reg [15:0] vector_addr_o,
	output reg [3:0] priority_o,
	output wire [15:0] handler_addr_o,
	// Clock controls and the flag interrupt
	output reg cpu_en_o,
	output reg mclk_en_o,
	output reg sub_main_clock_en_o,
	output reg aclk_en_o,
	output reg fll_en_o,
	output reg osc_out_en_o,
	output reg dc_gen_en_o,
	output reg xtal_en_o,
	output reg irq_o
);
	// Software-visible control state
	reg [7:0] src_en_q;
	reg [`FLAGS_W-1:0] mask_q;
	reg [2:0] mode_q;

	// Reset, wake and nesting state
	reg reset_pend_q;
	reg wake_q;
	reg [3:0] nest_q;

	// Captured address phase
	reg wr_q;
	reg [7:0] waddr_q;

	// Combinational decode
	reg [15:0] pend;
	reg [3:0] best;
	reg any_pend;
	reg in_periph;
	reg in_hole;
	reg bad_fetch;
	reg [`FLAGS_W-1:0] set_fl;
	reg [`FLAGS_W-1:0] clr_fl;
	reg [7:0] clk_pat;
	reg [31:0] rd_d;

	// Nets between processes
	wire [`FLAGS_W-1:0] flags;
	wire [2:0] eff_mode;
	wire sleeping;
	wire reset_event;
	wire reset_ack;
	wire addr_ok;
	wire wr_vec;
	integer i;

	// Address phase accepted
	assign addr_ok = hsel_i & htrans_i[1] & hready_i;

	// Bad fetch: peripheral registers or unused hole
	always @* begin
		in_periph = (fetch_addr_i <= `PERIPH_LAST);
		in_hole = (fetch_addr_i >= `HOLE_FIRST) && (fetch_addr_i <= `HOLE_LAST);
		bad_fetch = fetch_valid_i & (in_periph | in_hole);
	end

	// All reset sources funnel into the top vector
	assign reset_event = ext_reset_i | watchdog_expire_i | key_violation_i | bad_fetch;

	// Reset vector being taken by the core
	assign reset_ack = int_ack_i && (priority_o == `PRI_RESET);

	// Flag events and software write-one-to-clear
	always @* begin
		set_fl = {`FLAGS_W{1'b0}};
		set_fl[`FL_NMI_PIN] = nmi_pin_i;
		set_fl[`FL_OSC_FAULT] = osc_fault_i;
		set_fl[`FL_ACC_VIOL] = flash_access_viol_i;
		set_fl[`FL_WATCHDOG] = watchdog_expire_i;
		set_fl[`FL_KEY_VIOL] = key_violation_i;
		set_fl[`FL_BAD_FETCH] = bad_fetch;
		clr_fl = {`FLAGS_W{1'b0}};
		if (wr_q && waddr_q == `OFS_FLAGS) begin
			clr_fl = hwdata_i[`FLAGS_W-1:0];
		end
	end

	sticky_flags #(
		.W(`FLAGS_W),
		.RST_VAL(`FLAGS_RST)
	) u_flags (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.set_i(set_fl),
		.clr_i(clr_fl),
		.flags_o(flags)
	);

	// Pending map indexed by priority; maskable ones need the global enable
	always @* begin
		pend = 16'h0000;
		pend[`PRI_RESET] = reset_pend_q;
		pend[`PRI_NMI] = (flags[`FL_NMI_PIN] & src_en_q[`EN_NMI_PIN]) |
			(flags[`FL_OSC_FAULT] & src_en_q[`EN_OSC_FAULT]) |
			(flags[`FL_ACC_VIOL] & src_en_q[`EN_ACC_VIOL]);
		pend[`PRI_CONVERTER] = converter_req_i & src_en_q[`EN_CONVERTER] & gie_i;
		pend[`PRI_TIMER] = timer_req_i & src_en_q[`EN_TIMER] & gie_i;
		pend[`PRI_PORT_ONE] = (|port_one_change_flags_i) & src_en_q[`EN_PORT_ONE] & gie_i;
		pend[`PRI_PORT_TWO] = (|port_two_change_flags_i) & src_en_q[`EN_PORT_TWO] & gie_i;
	end

	// Highest priority number wins; lower ones simply stay pending
	always @* begin
		best = 4'h0;
		any_pend = 1'b0;
		for (i = 0; i < 16; i = i + 1) begin
			if (pend[i]) begin
				best = i[3:0];
				any_pend = 1'b1;
			end
		end
	end

	// Reset request: set at power-up and by any reset source
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reset_pend_q <= 1'b1;
		end else if (reset_event) begin
			reset_pend_q <= 1'b1;
		end else if (reset_ack) begin
			reset_pend_q <= 1'b0;
		end
	end

	// Vector outputs; word address is the low vector plus twice the priority
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			int_req_o <= 1'b0;
			reset_req_o <= 1'b0;
			vector_addr_o <= `VEC_TOP;
			priority_o <= 4'h0;
		end else begin
			int_req_o <= any_pend & ~int_ack_i;
			reset_req_o <= pend[`PRI_RESET] & ~int_ack_i;
			vector_addr_o <= `VEC_LOW | {11'h000, best, 1'b0};
			priority_o <= best;
		end
	end

	// Handler word for the chosen vector, one cycle after the vector
	vector_table u_vectors (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.wr_en_i(wr_vec),
		.wr_idx_i(waddr_q[5:2]),
		.wr_data_i(hwdata_i[15:0]),
		.rd_idx_i(priority_o),
		.rd_data_o(handler_addr_o)
	);

	// Vector table spans offsets 40h to 7Ch
	assign wr_vec = wr_q & (waddr_q >= `OFS_VEC_BASE) & (waddr_q[7] == 1'b0);

	// Effective mode: handler activity forces the core awake
	assign eff_mode = (wake_q || nest_q != 4'h0) ? `MODE_ACTIVE : mode_q;
	assign sleeping = (mode_q != `MODE_ACTIVE) && !wake_q && nest_q == 4'h0;

	// Wake flag and handler nesting depth
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wake_q <= 1'b0;
			nest_q <= 4'h0;
		end else begin
			// Reset vector taken: forget all handler state
			if (reset_ack) begin
				wake_q <= 1'b0;
				nest_q <= 4'h0;
			end else if (int_ack_i) begin
				wake_q <= 1'b0;
				if (nest_q != 4'hF) begin
					nest_q <= nest_q + 4'h1;
				end
			end else begin
				if (sleeping && any_pend) begin
					wake_q <= 1'b1;
				end
				if (reti_i && nest_q != 4'h0) begin
					nest_q <= nest_q - 4'h1;
				end
			end
		end
	end

	// Clock pattern per effective mode
	always @* begin
		case (eff_mode)
			`MODE_ACTIVE: clk_pat = `CLK_ACTIVE;
			`MODE_SLEEP0: clk_pat = `CLK_SLEEP0;
			`MODE_SLEEP1: clk_pat = `CLK_SLEEP1;
			`MODE_SLEEP2: clk_pat = `CLK_SLEEP2;
			`MODE_SLEEP3: clk_pat = `CLK_SLEEP3;
			`MODE_SLEEP4: clk_pat = `CLK_SLEEP4;
			// Unused codes keep every clock running
			default: clk_pat = `CLK_ACTIVE;
		endcase
	end

	// Registered clock controls
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cpu_en_o <= 1'b1;
			mclk_en_o <= 1'b1;
			sub_main_clock_en_o <= 1'b1;
			aclk_en_o <= 1'b1;
			fll_en_o <= 1'b1;
			osc_out_en_o <= 1'b1;
			dc_gen_en_o <= 1'b1;
			xtal_en_o <= 1'b1;
		end else begin
			cpu_en_o <= clk_pat[`CK_CPU];
			mclk_en_o <= clk_pat[`CK_MCLK];
			sub_main_clock_en_o <= clk_pat[`CK_SUB_MAIN_CLOCK];
			aclk_en_o <= clk_pat[`CK_ACLK];
			fll_en_o <= clk_pat[`CK_FLL];
			osc_out_en_o <= clk_pat[`CK_OSC_OUT];
			dc_gen_en_o <= clk_pat[`CK_DC_GEN];
			xtal_en_o <= clk_pat[`CK_XTAL];
		end
	end

	// Bus address phase capture; zero wait states
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_q <= 1'b0;
			waddr_q <= 8'h00;
		end else begin
			wr_q <= addr_ok & hwrite_i & (haddr_i[31:8] == 24'h000000);
			waddr_q <= {haddr_i[7:2], 2'b00};
		end
	end

	// Always ready and always OKAY, so no wait or error path exists
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

	// Register writes in the data phase
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			src_en_q <= `SRC_EN_RST;
			mask_q <= `MASK_RST;
			mode_q <= `MODE_RST;
		end else if (reset_ack) begin
			mode_q <= `MODE_RST;
		end else if (wr_q) begin
			case (waddr_q)
				`OFS_SRC_EN: src_en_q <= hwdata_i[7:0];
				`OFS_IRQ_MASK: mask_q <= hwdata_i[`FLAGS_W-1:0];
				`OFS_SLEEP: mode_q <= (hwdata_i[2:0] > `MODE_SLEEP4) ? mode_q : hwdata_i[2:0];
				default: mode_q <= mode_q;
			endcase
		end
	end

	// Read mux, registered into the data phase
	always @* begin
		rd_d = 32'h00000000;
		case ({haddr_i[7:2], 2'b00})
			`OFS_SRC_EN: rd_d[7:0] = src_en_q;
			`OFS_FLAGS: rd_d[`FLAGS_W-1:0] = flags;
			`OFS_IRQ_MASK: rd_d[`FLAGS_W-1:0] = mask_q;
			`OFS_SLEEP: rd_d[2:0] = mode_q;
			`OFS_STATUS: begin
				rd_d[15:0] = vector_addr_o;
				rd_d[`ST_BEST_LSB +: 4] = best;
				rd_d[`ST_ANY_BIT] = any_pend;
				rd_d[`ST_MODE_LSB +: 3] = eff_mode;
				rd_d[`ST_NEST_LSB +: 4] = nest_q;
			end
			default: rd_d = 32'h00000000;
		endcase
		if (haddr_i[31:8] != 24'h000000) begin
			rd_d = 32'h00000000;
		end
	end

	// Read data stands until the next read is taken
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hrdata_o <= 32'h00000000;
		end else if (addr_ok && !hwrite_i) begin
			hrdata_o <= rd_d;
		end
	end

	// Level interrupt from unmasked sticky flags
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(flags & mask_q);
		end
	end
endmodule
`default_nettype wire

// [rtl/sticky_flags.v]
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
	parameter W = 6,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	input wire mclk_i,
	input wire reset_n_i,
	input wire [W-1:0] set_i,
	input wire [W-1:0] clr_i,
	output reg [W-1:0] flags_o
);
	// Set beats clear so no event is lost in the clearing cycle
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flags_o <= RST_VAL;
		end else begin
			flags_o <= (flags_o & ~clr_i) | set_i;
		end
	end
endmodule
`default_nettype wire

// [rtl/vector_table.v]
`timescale 1ns/1ps
`default_nettype none
module vector_table (
	input wire mclk_i,
	input wire reset_n_i,
	input wire wr_en_i,
	input wire [3:0] wr_idx_i,
	input wire [15:0] wr_data_i,
	input wire [3:0] rd_idx_i,
	output reg [15:0] rd_data_o
);
	reg [15:0] mem [0:15];

	// Storage has no reset; software loads handlers before use
	always @(posedge mclk_i) begin
		if (wr_en_i) begin
			mem[wr_idx_i] <= wr_data_i;
		end
	end

	// Registered read of the handler word
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_o <= 16'h0000;
		end else begin
			rd_data_o <= mem[rd_idx_i];
		end
	end
endmodule
`default_nettype wire

// [tb/core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic int_req_i,
	input wire logic [15:0] handler_addr_i,
	input wire logic [3:0] dly_i,
	output logic int_ack_o,
	output logic reti_o,
	output logic [15:0] taken_o
);
	// Take request, load handler word, return after dly_i cycles
	initial begin
		int_ack_o = 1'b0;
		reti_o = 1'b0;
		taken_o = 16'h0000;
		forever begin
			@(posedge mclk_i);
			if (reset_n_i && int_req_i === 1'b1) begin
				@(posedge mclk_i);
				taken_o <= handler_addr_i;
				int_ack_o <= 1'b1;
				@(posedge mclk_i);
				int_ack_o <= 1'b0;
				repeat (dly_i) @(posedge mclk_i);
				reti_o <= 1'b1;
				@(posedge mclk_i);
				reti_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// [tb/ivp_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module ivp_assertions (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic fetch_valid_i,
	input wire logic [15:0] fetch_addr_i,
	input wire logic int_req_o,
	input wire logic reset_req_o,
	input wire logic [15:0] vector_addr_o,
	input wire logic [3:0] priority_o,
	input wire logic cpu_en_o,
	input wire logic mclk_en_o,
	input wire logic aclk_en_o,
	input wire logic fll_en_o,
	input wire logic osc_out_en_o,
	input wire logic dc_gen_en_o,
	input wire logic xtal_en_o
);
	// One clock domain, so one default for all
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	// Fetch into register space or the unused hole
	wire logic bad_fetch = fetch_valid_i && (fetch_addr_i <= 16'h01FF ||
		(fetch_addr_i >= 16'h0600 && fetch_addr_i <= 16'h0BFF));
	vec_word_a: assert property (int_req_o |->
		vector_addr_o == 16'hFFE0 + {11'h000, priority_o, 1'b0}) else $error("vector word off");
	reset_top_a: assert property (reset_req_o && int_req_o |->
		priority_o == 4'hF && vector_addr_o == 16'hFFFE) else $error("reset not on top");
	fetch_trap_a: assert property (bad_fetch |-> ##[1:2] reset_req_o)
		else $error("bad fetch no reset");
	wake_up_a: assert property ($rose(int_req_o) |=> cpu_en_o && mclk_en_o)
		else $error("no wake on request");
	level_zero_a: assert property (!cpu_en_o && fll_en_o |-> mclk_en_o && aclk_en_o)
		else $error("level zero clocks");
	level_one_a: assert property (!fll_en_o |-> !cpu_en_o && aclk_en_o == xtal_en_o)
		else $error("loop off while cpu on");
	level_two_a: assert property (!mclk_en_o |-> !fll_en_o && !osc_out_en_o && !cpu_en_o)
		else $error("level two clocks");
	level_three_a: assert property (!dc_gen_en_o |-> !mclk_en_o && !osc_out_en_o)
		else $error("generator off too early");
	level_four_a: assert property (!xtal_en_o |-> !aclk_en_o && !dc_gen_en_o)
		else $error("crystal off, others on");
endmodule
bind int_vector_ctrl ivp_assertions chk (.*);
`default_nettype wire

// [tb/tb_int_vector_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_int_vector_ctrl;
	logic mclk_i = 1'b0, reset_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, gie_i = 1'b0;
	logic ext_reset_i = 1'b0, watchdog_expire_i = 1'b0, key_violation_i = 1'b0;
	logic nmi_pin_i = 1'b0, osc_fault_i = 1'b0, flash_access_viol_i = 1'b0, fetch_valid_i = 1'b0;
	logic converter_req_i = 1'b0, timer_req_i = 1'b0;
	logic [7:0] port_one_change_flags_i = 8'h00, port_two_change_flags_i = 8'h00;
	logic [1:0] htrans_i = 2'h0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, rd;
	logic [15:0] fetch_addr_i = 16'h0000;
	logic [3:0] dly = 4'h1;
	wire logic hready_i, hreadyout_o, hresp_o, int_ack_i, reti_i, int_req_o, reset_req_o, irq_o;
	wire logic cpu_en_o, mclk_en_o, sub_main_clock_en_o, aclk_en_o, fll_en_o, osc_out_en_o;
	wire logic dc_gen_en_o, xtal_en_o;
	wire logic [31:0] hrdata_o;
	wire logic [15:0] vector_addr_o, handler_addr_o, taken;
	wire logic [3:0] priority_o;
	int err_count = 0, n_compared = 0, i, w;
	logic [7:0] pat [6] = '{8'hFF, 8'hFE, 8'hEE, 8'hC8, 8'h88, 8'h00};
	logic [15:0] fad [5] = '{16'h01FF, 16'h0200, 16'h0600, 16'h0BFF, 16'h0C00};
	logic [17:0] src [4] = '{18'h20000, 18'h10000, 18'h00800, 18'h00001};
	logic [3:0] pri [4] = '{4'hC, 4'h5, 4'h4, 4'h1};
	// Clock enables gathered, one master, single slave
	wire logic [7:0] ck = {xtal_en_o, dc_gen_en_o, osc_out_en_o, fll_en_o,
		aclk_en_o, sub_main_clock_en_o, mclk_en_o, cpu_en_o};
	assign hready_i = hreadyout_o;
	always #25 mclk_i = ~mclk_i;
	int_vector_ctrl uut (.*);
	core_model core (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .int_req_i(int_req_o),
		.handler_addr_i(handler_addr_o), .dly_i(dly), .int_ack_o(int_ack_i),
		.reti_o(reti_i), .taken_o(taken));
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task chb(input string n, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %b got %b", n, e, g);
		end
	endtask
	// One single word transfer; waits on hready, never counts cycles
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= {24'h0, a};
		hwrite_i <= wr;
		do @(posedge mclk_i); while (hready_i !== 1'b1);
		htrans_i <= 2'h0;
		hsel_i <= 1'b0;
		hwdata_i <= d;
		do @(posedge mclk_i); while (hready_i !== 1'b1);
		rd = hrdata_o;
		chb("okay", 1'b0, hresp_o);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
		bus(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask
	// Always eats one edge, so a falling ack is not seen twice
	task wack;
		w = 0;
		do begin
			@(posedge mclk_i);
			w++;
		end while (int_ack_i !== 1'b1 && w < 40);
		chb("ack", 1'b1, int_ack_i);
	endtask
	task t_reset;
		chb("rst req", 1'b1, reset_req_o);
		chk("rst vec", 32'hFFFE, {16'h0, vector_addr_o});
		rdc(8'h04, 32'h2, "flags");
		rdc(8'h08, 32'h0, "mask");
		bus(1'b1, 8'h04, 32'h3F);
		rdc(8'h04, 32'h0, "w1c");
		rdc(8'h20, 32'h0, "hole");
		for (i = 0; i < 16; i++)
			bus(1'b1, 8'(64 + 4 * i), 32'hC000 + 32'(i));
		rdc(8'h44, 32'h0, "vec wo");
		$display("reset done");
	endtask
	// Each maskable source, then two at once
	task t_mask;
		gie_i <= 1'b1;
		bus(1'b1, 8'h00, 32'hF0);
		rdc(8'h00, 32'hF0, "enables");
		for (i = 0; i < 4; i++) begin
			{converter_req_i, timer_req_i, port_one_change_flags_i, port_two_change_flags_i} <= src[i];
			wack;
			{converter_req_i, timer_req_i, port_one_change_flags_i, port_two_change_flags_i} <= 18'h0;
			chk("handler", 32'hC000 + pri[i], {16'h0, taken});
			repeat (4) @(posedge mclk_i);
		end
		timer_req_i <= 1'b1;
		port_two_change_flags_i <= 8'h80;
		wack;
		timer_req_i <= 1'b0;
		chk("first", 32'hC005, {16'h0, taken});
		wack;
		port_two_change_flags_i <= 8'h00;
		chk("second", 32'hC001, {16'h0, taken});
		gie_i <= 1'b0;
		port_one_change_flags_i <= 8'h01;
		repeat (5) @(posedge mclk_i);
		chb("gie off", 1'b0, int_req_o);
		gie_i <= 1'b1;
		wack;
		port_one_change_flags_i <= 8'h00;
		chk("late", 32'hC004, {16'h0, taken});
		repeat (4) @(posedge mclk_i);
		$display("mask done");
	endtask
	// Own enable blocks, global enable does not
	task t_nmi;
		gie_i <= 1'b0;
		dly <= 4'hF;
		bus(1'b1, 8'h00, 32'h01);
		bus(1'b1, 8'h08, 32'h01);
		osc_fault_i <= 1'b1;
		@(posedge mclk_i);
		osc_fault_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		chb("own en", 1'b0, int_req_o);
		nmi_pin_i <= 1'b1;
		@(posedge mclk_i);
		nmi_pin_i <= 1'b0;
		wack;
		chk("nmi", 32'hC00E, {16'h0, taken});
		chb("irq", 1'b1, irq_o);
		rdc(8'h10, 32'h011EFFFC, "status");
		bus(1'b1, 8'h08, 32'h0);
		repeat (2) @(posedge mclk_i);
		chb("masked", 1'b0, irq_o);
		bus(1'b1, 8'h08, 32'h01);
		rdc(8'h04, 32'h3, "own flags");
		bus(1'b1, 8'h04, 32'h3);
		repeat (2) @(posedge mclk_i);
		chb("cleared", 1'b0, irq_o);
		repeat (40) @(posedge mclk_i);
		$display("nmi done");
	endtask
	task t_sleep;
		dly <= 4'h8;
		gie_i <= 1'b1;
		bus(1'b1, 8'h00, 32'hF0);
		for (i = 1; i < 6; i++) begin
			bus(1'b1, 8'h0C, 32'(i));
			repeat (2) @(posedge mclk_i);
			chk("clocks", {24'h0, pat[i]}, {24'h0, ck});
		end
		// Codes above the deepest level are refused
		bus(1'b1, 8'h0C, 32'h7);
		rdc(8'h0C, 32'h5, "bad code");
		port_one_change_flags_i <= 8'h10;
		repeat (3) @(posedge mclk_i);
		chk("woken", 32'hFF, {24'h0, ck});
		wack;
		port_one_change_flags_i <= 8'h00;
		repeat (14) @(posedge mclk_i);
		chk("back", 32'h0, {24'h0, ck});
		port_one_change_flags_i <= 8'h02;
		wack;
		port_one_change_flags_i <= 8'h00;
		bus(1'b1, 8'h0C, 32'h0);
		repeat (12) @(posedge mclk_i);
		chk("altered", 32'hFF, {24'h0, ck});
		$display("sleep done");
	endtask
	// Reset sources, then fetch ranges at their edges
	task t_rst;
		dly <= 4'h1;
		for (i = 0; i < 3; i++) begin
			{ext_reset_i, watchdog_expire_i, key_violation_i} <= 3'h4 >> i;
			@(posedge mclk_i);
			{ext_reset_i, watchdog_expire_i, key_violation_i} <= 3'h0;
			// Pending bit lands first, the request one edge later
			repeat (2) @(posedge mclk_i);
			chk("rst src", 32'h0001FFFE, {15'h0, reset_req_o, vector_addr_o});
			wack;
			repeat (3) @(posedge mclk_i);
		end
		for (i = 0; i < 5; i++) begin
			fetch_valid_i <= 1'b1;
			fetch_addr_i <= fad[i];
			@(posedge mclk_i);
			fetch_valid_i <= 1'b0;
			repeat (2) @(posedge mclk_i);
			chb("fetch", (5'b01101 >> i) & 1'b1, reset_req_o);
			if (reset_req_o === 1'b1)
				wack;
			repeat (3) @(posedge mclk_i);
		end
		$display("fetch done");
	endtask
	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		t_reset;
		t_mask;
		t_nmi;
		t_sleep;
		t_rst;
		wrap_up;
	end
	// Run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge mclk_i);
		err_count++;
		wrap_up;
	end
endmodule
`default_nettype wire
